//--- inc/i2c_flags_pkg.sv
// Shared constants and types for the fast low count and event flag block
package i2c_flags_pkg;

	localparam logic [31:0] FAST_LOW_ADDR     = 32'h5000_1320;
	localparam logic [31:0] INTR_STAT_ADDR    = 32'h5000_132c;
	localparam logic [31:0] CLR_INTR_ADDR     = 32'h5000_1340;
	localparam logic [31:0] CLR_ACT_ADDR      = 32'h5000_135c;
	localparam logic [31:0] CLR_GEN_CALL_ADDR = 32'h5000_1368;
	localparam logic [31:0] ENABLE_ADDR       = 32'h5000_136c;

	localparam logic [15:0] FAST_LOW_RESET = 16'h0017;
	localparam logic [15:0] FAST_LOW_MIN   = 16'h0008;

	localparam int GEN_CALL_BIT = 11;
	localparam int START_BIT    = 10;
	localparam int STOP_BIT     = 9;
	localparam int ACTIVITY_BIT = 8;
	localparam int ENABLE_BIT   = 0;
	localparam int STATUS_MSB   = 15;

	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [3:0] BYTE_BITS     = 4'h8;

	typedef struct packed {
		logic busy;
		logic rx_tgl;
		logic gc_tgl;
		logic stop_tgl;
		logic start_tgl;
	} link_evt_s;

	localparam int LINK_EVT_W = $bits(link_evt_s);

	typedef enum logic [1:0] {
		MON_IDLE  = 2'b00,
		MON_SHIFT = 2'b01,
		MON_ACK   = 2'b11,
		MON_SKIP  = 2'b10
	} mon_state_e;

endpackage

//--- rtl/i2c_bus_monitor.sv
// Link-side bus watcher: START/STOP, general call acknowledge, data bytes
`timescale 1ns/1ps
module i2c_bus_monitor
	import i2c_flags_pkg::*;
(
	input  wire logic       link_clk,
	input  wire logic       rst,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       enable_in,
	output logic            sda_o,
	output logic            sda_oe,
	output link_evt_s       evt,
	output logic      [7:0] rx_byte
);

	logic       scl_s;
	logic       sda_s;
	logic       en_s;
	mon_state_e state_reg,   state_next;
	logic [3:0] bits_reg,    bits_next;
	logic [7:0] shift_reg,   shift_next;
	logic       first_reg,   first_next;
	logic       gc_txn_reg,  gc_txn_next;
	logic       scl_prev_reg, scl_prev_next;
	logic       sda_prev_reg, sda_prev_next;
	logic       ack_reg,     ack_next;
	link_evt_s  evt_reg,     evt_next;
	logic [7:0] rx_byte_reg, rx_byte_next;
	logic       start_c;
	logic       stop_c;
	logic       rise_c;
	logic       fall_c;

	sync2 #(.WIDTH(3)) u_pin_sync (
		.clk (link_clk),
		.rst (rst),
		.d   ({scl_i, sda_i, enable_in}),
		.q   ({scl_s, sda_s, en_s})
	);

	always_comb
	begin
		start_c = en_s & scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
		stop_c  = en_s & scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
		rise_c  = scl_s & ~scl_prev_reg;
		fall_c  = ~scl_s & scl_prev_reg;
		state_next    = state_reg;
		bits_next     = bits_reg;
		shift_next    = shift_reg;
		first_next    = first_reg;
		gc_txn_next   = gc_txn_reg;
		ack_next      = ack_reg;
		evt_next      = evt_reg;
		rx_byte_next  = rx_byte_reg;
		scl_prev_next = scl_s;
		sda_prev_next = sda_s;
		case (state_reg)
			MON_IDLE:
			begin
				state_next = MON_IDLE;
			end
			MON_SHIFT:
			begin
				if (rise_c)
				begin
					shift_next = {shift_reg[6:0], sda_s};
					bits_next  = bits_reg + 4'h1;
				end
				else if (fall_c && bits_reg == BYTE_BITS)
				begin
					if ((first_reg && shift_reg == GEN_CALL_ADDR) ||
					    (!first_reg && gc_txn_reg))
					begin
						state_next = MON_ACK;
						ack_next   = 1'b1;
					end
					else
					begin
						state_next = MON_SKIP;
					end
				end
			end
			MON_ACK:
			begin
				if (fall_c)
				begin
					ack_next   = 1'b0;
					bits_next  = 4'h0;
					state_next = MON_SHIFT;
					first_next = 1'b0;
					if (first_reg)
					begin
						gc_txn_next     = 1'b1;
						evt_next.gc_tgl = ~evt_reg.gc_tgl;
					end
					else
					begin
						rx_byte_next    = shift_reg;
						evt_next.rx_tgl = ~evt_reg.rx_tgl;
					end
				end
			end
			MON_SKIP:
			begin
				state_next = MON_SKIP;
			end
			default:
			begin
				state_next = MON_IDLE;
			end
		endcase
		if (start_c)
		begin
			state_next         = MON_SHIFT;
			bits_next          = 4'h0;
			first_next         = 1'b1;
			gc_txn_next        = 1'b0;
			ack_next           = 1'b0;
			evt_next.busy      = 1'b1;
			evt_next.start_tgl = ~evt_reg.start_tgl;
		end
		if (stop_c)
		begin
			state_next        = MON_IDLE;
			ack_next          = 1'b0;
			evt_next.busy     = 1'b0;
			evt_next.stop_tgl = ~evt_reg.stop_tgl;
		end
		if (!en_s)
		begin
			state_next    = MON_IDLE;
			ack_next      = 1'b0;
			evt_next.busy = 1'b0;
		end
	end

	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= MON_IDLE;
			bits_reg     <= 4'h0;
			shift_reg    <= 8'h00;
			first_reg    <= 1'b0;
			gc_txn_reg   <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			ack_reg      <= 1'b0;
			evt_reg      <= '0;
			rx_byte_reg  <= 8'h00;
		end
		else
		begin
			state_reg    <= state_next;
			bits_reg     <= bits_next;
			shift_reg    <= shift_next;
			first_reg    <= first_next;
			gc_txn_reg   <= gc_txn_next;
			scl_prev_reg <= scl_prev_next;
			sda_prev_reg <= sda_prev_next;
			ack_reg      <= ack_next;
			evt_reg      <= evt_next;
			rx_byte_reg  <= rx_byte_next;
		end
	end

	assign sda_o   = 1'b0;
	assign sda_oe  = ack_reg;
	assign evt     = evt_reg;
	assign rx_byte = rx_byte_reg;

endmodule

//--- rtl/i2c_fast_count_status.sv
// Fast SCL low count register and bus event status flags, APB slave
`timescale 1ns/1ps
// Function
// - 16-bit fast low count, resets to 0x17
// - Count writes ignored while controller enabled
// - Writes below 8 store 8
// - Fast count times SCL for special sends
// - General call flag set on acked address
// - General call flag held until disable/clear-read
// - General call data bytes go to receive
// - Start flag set on START or RESTART
// - Stop flag set on STOP
// - Sticky activity flag set on bus activity
// - Activity cleared: disable, clear reads, reset
module i2c_fast_count_status
	import i2c_flags_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        core_active,
	input  wire logic        special_send,
	input  wire logic [15:0] std_low_count,
	output logic      [15:0] scl_low_count,
	output logic             ctrl_enable,
	output logic      [7:0]  rx_data,
	output logic             rx_valid
);

	function automatic logic hit(input logic [31:0] a,
	                             input logic [31:0] base);
		return a == base;
	endfunction

	link_evt_s   evt_link;
	link_evt_s   evt_sync;
	logic [7:0]  rx_byte_in;
	logic        enable_reg,   enable_next;
	logic [15:0] fast_low_reg, fast_low_next;
	logic        gc_reg,       gc_next;
	logic        start_reg,    start_next;
	logic        stop_reg,     stop_next;
	logic        act_reg,      act_next;
	link_evt_s   prev_reg,     prev_next;
	logic [7:0]  rx_data_reg,  rx_data_next;
	logic        rx_valid_reg, rx_valid_next;
	logic [31:0] prdata_reg,   prdata_next;
	logic [15:0] scl_low_reg,  scl_low_next;
	logic        rd_access;
	logic        wr_access;
	logic        rd_setup;
	logic        mapped;
	logic        clr_all;
	logic        clr_act;
	logic        clr_gc;
	logic        start_p;
	logic        stop_p;
	logic        gc_p;
	logic        rx_p;
	logic [31:0] status_word;

	i2c_bus_monitor u_monitor (
		.link_clk  (link_clk),
		.rst       (rst),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.enable_in (enable_reg),
		.sda_o     (sda_o),
		.sda_oe    (sda_oe),
		.evt       (evt_link),
		.rx_byte   (rx_byte_in)
	);

	sync2 #(.WIDTH(LINK_EVT_W)) u_evt_sync (
		.clk (clk),
		.rst (rst),
		.d   (evt_link),
		.q   (evt_sync)
	);

	// Bus decode and toggle-to-pulse conversion
	always_comb
	begin
		rd_access = psel & penable & ~pwrite;
		wr_access = psel & penable & pwrite;
		rd_setup  = psel & ~penable & ~pwrite;
		mapped    = hit(paddr, FAST_LOW_ADDR) | hit(paddr, INTR_STAT_ADDR) |
		            hit(paddr, CLR_INTR_ADDR) | hit(paddr, CLR_ACT_ADDR) |
		            hit(paddr, CLR_GEN_CALL_ADDR) | hit(paddr, ENABLE_ADDR);
		clr_all   = rd_access & hit(paddr, CLR_INTR_ADDR);
		clr_act   = clr_all | (rd_access & hit(paddr, CLR_ACT_ADDR));
		clr_gc    = clr_all | (rd_access & hit(paddr, CLR_GEN_CALL_ADDR));
		start_p   = evt_sync.start_tgl ^ prev_reg.start_tgl;
		stop_p    = evt_sync.stop_tgl ^ prev_reg.stop_tgl;
		gc_p      = evt_sync.gc_tgl ^ prev_reg.gc_tgl;
		rx_p      = evt_sync.rx_tgl ^ prev_reg.rx_tgl;
	end

	// Software-written control: enable and fast low count
	always_comb
	begin
		enable_next   = enable_reg;
		fast_low_next = fast_low_reg;
		if (wr_access && hit(paddr, ENABLE_ADDR))
		begin
			enable_next = pwdata[ENABLE_BIT];
		end
		if (wr_access && hit(paddr, FAST_LOW_ADDR) && !enable_reg)
		begin
			if (pwdata[15:0] < FAST_LOW_MIN)
			begin
				fast_low_next = FAST_LOW_MIN;
			end
			else
			begin
				fast_low_next = pwdata[15:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			enable_reg   <= 1'b0;
			fast_low_reg <= FAST_LOW_RESET;
		end
		else
		begin
			enable_reg   <= enable_next;
			fast_low_reg <= fast_low_next;
		end
	end

	// Sticky flags: a set in the clear cycle wins, disable clears all
	always_comb
	begin
		gc_next    = enable_reg & (gc_p | (gc_reg & ~clr_gc));
		start_next = enable_reg & (start_p | (start_reg & ~clr_all));
		stop_next  = enable_reg & (stop_p | (stop_reg & ~clr_all));
		act_next   = enable_reg & (evt_sync.busy | core_active |
		             (act_reg & ~clr_act));
		prev_next     = evt_sync;
		rx_valid_next = rx_p;
		rx_data_next  = rx_p ? rx_byte_in : rx_data_reg;
		scl_low_next  = special_send ? fast_low_reg : std_low_count;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gc_reg       <= 1'b0;
			start_reg    <= 1'b0;
			stop_reg     <= 1'b0;
			act_reg      <= 1'b0;
			prev_reg     <= '0;
			rx_valid_reg <= 1'b0;
			rx_data_reg  <= 8'h00;
			scl_low_reg  <= 16'h0000;
		end
		else
		begin
			gc_reg       <= gc_next;
			start_reg    <= start_next;
			stop_reg     <= stop_next;
			act_reg      <= act_next;
			prev_reg     <= prev_next;
			rx_valid_reg <= rx_valid_next;
			rx_data_reg  <= rx_data_next;
			scl_low_reg  <= scl_low_next;
		end
	end

	// Read data is captured in the setup phase
	always_comb
	begin
		status_word               = 32'h0000_0000;
		status_word[GEN_CALL_BIT] = gc_reg;
		status_word[START_BIT]    = start_reg;
		status_word[STOP_BIT]     = stop_reg;
		status_word[ACTIVITY_BIT] = act_reg;
		prdata_next = prdata_reg;
		if (rd_setup)
		begin
			if (hit(paddr, FAST_LOW_ADDR))
			begin
				prdata_next = {16'h0000, fast_low_reg};
			end
			else if (hit(paddr, INTR_STAT_ADDR))
			begin
				prdata_next = status_word;
			end
			else if (hit(paddr, ENABLE_ADDR))
			begin
				prdata_next = {31'h0000_0000, enable_reg};
			end
			else
			begin
				prdata_next = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			prdata_reg <= prdata_next;
		end
	end

	assign prdata        = prdata_reg;
	assign pready        = 1'b1;
	assign pslverr       = psel & penable & ~mapped;
	assign scl_low_count = scl_low_reg;
	assign ctrl_enable   = enable_reg;
	assign rx_data       = rx_data_reg;
	assign rx_valid      = rx_valid_reg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Count register: store, lock, clamp, read back, speed select
	a_count_store: assert property (
		wr_access && hit(paddr, FAST_LOW_ADDR) && !enable_reg
		&& pwdata[15:0] >= FAST_LOW_MIN
		|=> fast_low_reg == $past(pwdata[15:0]))
		else $error("fast low count did not store written value");
	a_count_read: assert property (
		rd_access && hit(paddr, FAST_LOW_ADDR)
		|-> prdata == {16'h0000, $past(fast_low_reg)})
		else $error("fast low count read back wrong");
	a_write_blocked: assert property (
		wr_access && hit(paddr, FAST_LOW_ADDR) && enable_reg
		|=> $stable(fast_low_reg))
		else $error("fast low count changed while enabled");
	a_count_clamp: assert property (
		wr_access && hit(paddr, FAST_LOW_ADDR) && !enable_reg
		&& pwdata[15:0] < FAST_LOW_MIN
		|=> fast_low_reg == FAST_LOW_MIN ##1 fast_low_reg >= FAST_LOW_MIN)
		else $error("small fast low count not clamped");
	a_count_floor: assert property (
		fast_low_reg >= FAST_LOW_MIN)
		else $error("fast low count below minimum");
	a_low_select: assert property (
		special_send |=> scl_low_count == $past(fast_low_reg))
		else $error("special send not timed by fast low count");
	a_std_select: assert property (
		!special_send |=> scl_low_count == $past(std_low_count))
		else $error("standard low count not selected");

	// General call flag and delivered data
	a_gc_cause: assert property (
		$rose(gc_reg) |-> $past(gc_p) && $past(enable_reg))
		else $error("general call flag set without acked address");
	a_gc_set: assert property (
		gc_p && enable_reg |=> gc_reg)
		else $error("general call flag not set");
	a_gc_hold: assert property (
		gc_reg && enable_reg && !clr_gc |=> gc_reg)
		else $error("general call flag dropped without clear");
	a_gc_clear: assert property (
		clr_gc && !gc_p |=> !gc_reg)
		else $error("general call flag not cleared by read");
	a_gc_disable: assert property (
		!enable_reg |=> !gc_reg)
		else $error("general call flag kept while disabled");
	a_rx_push: assert property (
		rx_p |=> rx_valid && rx_data == $past(rx_byte_in) ##1 !rx_valid)
		else $error("general call data byte not delivered once");
	a_rx_cause: assert property (
		rx_valid |-> $past(rx_p))
		else $error("data strobe without received byte");

	// Start, stop and activity flags, status word
	a_start_set: assert property (
		start_p && enable_reg |=> start_reg)
		else $error("start flag not set");
	a_start_cause: assert property (
		$rose(start_reg) |-> $past(start_p))
		else $error("start flag set without start");
	a_start_clear: assert property (
		(clr_all || !enable_reg) && !start_p |=> !start_reg)
		else $error("start flag not cleared");
	a_stop_set: assert property (
		stop_p && enable_reg |=> stop_reg)
		else $error("stop flag not set");
	a_stop_cause: assert property (
		$rose(stop_reg) |-> $past(stop_p))
		else $error("stop flag set without stop");
	a_stop_clear: assert property (
		(clr_all || !enable_reg) && !stop_p |=> !stop_reg)
		else $error("stop flag not cleared");
	a_act_sticky: assert property (
		act_reg && enable_reg && !clr_act |=> act_reg)
		else $error("activity flag dropped while idle");
	a_act_set: assert property (
		enable_reg && (core_active || evt_sync.busy) |=> act_reg)
		else $error("activity flag not set on activity");
	a_act_cause: assert property (
		$rose(act_reg) |-> $past(core_active) || $past(evt_sync.busy))
		else $error("activity flag set without activity");
	a_act_clear: assert property (
		(!enable_reg || (clr_act && !evt_sync.busy && !core_active))
		|=> !act_reg)
		else $error("activity flag not cleared");
	a_rsvd_zero: assert property (
		rd_access && hit(paddr, INTR_STAT_ADDR)
		|-> prdata[31:STATUS_MSB+1] == '0
		&& prdata[STATUS_MSB:GEN_CALL_BIT+1] == '0
		&& prdata[ACTIVITY_BIT-1:0] == '0)
		else $error("reserved status bits not zero");
	a_status_map: assert property (
		rd_access && hit(paddr, INTR_STAT_ADDR)
		|-> prdata[GEN_CALL_BIT] == $past(gc_reg)
		&& prdata[START_BIT] == $past(start_reg)
		&& prdata[STOP_BIT] == $past(stop_reg)
		&& prdata[ACTIVITY_BIT] == $past(act_reg))
		else $error("status bits do not match flags");

	c_gc_seen: cover property (gc_p ##1 gc_reg ##[1:1000] rx_valid);
	c_clamp: cover property (wr_access && hit(paddr, FAST_LOW_ADDR)
		&& !enable_reg && pwdata[15:0] < FAST_LOW_MIN);
	c_act_clear: cover property (act_reg && clr_act ##1 !act_reg);
	c_start_stop: cover property (start_reg ##[1:1000] stop_reg);
	c_count_locked: cover property (wr_access && enable_reg
		&& hit(paddr, FAST_LOW_ADDR));

endmodule

//--- rtl/sync2.sv
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	always_comb
	begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= '0;
			q_reg    <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign q = q_reg;

endmodule

//--- test/i2c_fast_count_status_tb.sv
// Testbench for the fast low count register and bus event flags
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
	begin \
		n_compared++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp); \
		end \
	end
module i2c_fast_count_status_tb
	import i2c_flags_pkg::*;
;
	logic        clk, rst, link_clk, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic        scl, sda_drv, sda_o, sda_oe, core_active, special_send;
	logic [15:0] std_low_count, scl_low_count;
	logic        ctrl_enable, rx_valid;
	logic [7:0]  rx_data, rx_last;
	int          rx_count, miscompares, n_compared;
	wire         sda_line;

	// Wired-AND of the master's drive and the block's pull-down
	assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);

	i2c_fast_count_status dut_u (
		.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link_clk, .scl_i(scl), .sda_i(sda_line),
		.sda_o, .sda_oe, .core_active, .special_send, .std_low_count,
		.scl_low_count, .ctrl_enable, .rx_data, .rx_valid
	);

	i2c_master_model master_u (
		.link_clk, .sda_line, .scl, .sda_drv
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#17;
		forever #40 link_clk = ~link_clk;
	end

	always @(posedge clk)
		if (rx_valid === 1'b1)
		begin
			rx_last <= rx_data;
			rx_count <= rx_count + 1;
		end

	task automatic apb(input logic w, input logic [31:0] a, d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rd_chk(input logic [31:0] a, e, input string m);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 32'h0, rd, err);
		`CHK(rd, e, m)
	endtask

	task automatic t_reset();
		rd_chk(FAST_LOW_ADDR, 32'h0000_0017, "count reset");
		rd_chk(INTR_STAT_ADDR, 32'h0, "status reset");
		rd_chk(ENABLE_ADDR, 32'h0, "enable reset");
	endtask

	task automatic t_count();
		wr(FAST_LOW_ADDR, 32'hffff_1234);
		rd_chk(FAST_LOW_ADDR, 32'h0000_1234, "count rw");
		wr(FAST_LOW_ADDR, 32'h0000_0007);
		rd_chk(FAST_LOW_ADDR, 32'h0000_0008, "below min");
		wr(FAST_LOW_ADDR, 32'h0000_0000);
		rd_chk(FAST_LOW_ADDR, 32'h0000_0008, "zero");
		wr(FAST_LOW_ADDR, 32'h0000_0009);
		rd_chk(FAST_LOW_ADDR, 32'h0000_0009, "above min");
		wr(ENABLE_ADDR, 32'h0000_0001);
		wr(FAST_LOW_ADDR, 32'h0000_4321);
		rd_chk(FAST_LOW_ADDR, 32'h0000_0009, "locked");
		`CHK(ctrl_enable, 1'b1, "enable out")
		@(posedge clk);
		special_send <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(scl_low_count, 16'h0009, "fast select")
		special_send <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(scl_low_count, 16'h00aa, "std select")
		wr(ENABLE_ADDR, 32'h0);
		wr(FAST_LOW_ADDR, 32'h0000_4321);
		rd_chk(FAST_LOW_ADDR, 32'h0000_4321, "unlocked");
		`CHK(ctrl_enable, 1'b0, "enable off")
	endtask

	task automatic t_status();
		logic [31:0] rd;
		logic        err;
		wr(ENABLE_ADDR, 32'h0000_0001);
		wr(INTR_STAT_ADDR, 32'hffff_ffff);
		rd_chk(INTR_STAT_ADDR, 32'h0, "status write");
		apb(1'b0, 32'h5000_1330, 32'h0, rd, err);
		`CHK(err, 1'b1, "unmapped error")
		`CHK(pready, 1'b1, "no wait state")
	endtask

	// Three ways of clearing the sticky activity flag
	task automatic t_activity();
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			core_active <= 1'b1;
			repeat (3) @(posedge clk);
			core_active <= 1'b0;
			repeat (4) @(posedge clk);
			rd_chk(INTR_STAT_ADDR, 32'h0000_0100, "sticky");
			if (k == 0)
				rd_chk(CLR_ACT_ADDR, 32'h0, "act clear");
			else if (k == 1)
				rd_chk(CLR_INTR_ADDR, 32'h0, "all clear");
			else
			begin
				wr(ENABLE_ADDR, 32'h0);
				wr(ENABLE_ADDR, 32'h0000_0001);
			end
			rd_chk(INTR_STAT_ADDR, 32'h0, "act cleared");
		end
	endtask

	task automatic t_gen_call();
		logic ack;
		master_u.start_cond();
		master_u.send_byte(8'h00, ack);
		`CHK(ack, 1'b1, "gc ack")
		master_u.send_byte(8'ha5, ack);
		`CHK(ack, 1'b1, "data ack")
		master_u.stop_cond();
		`CHK(rx_last, 8'ha5, "gc data")
		`CHK(rx_count, 1, "gc count")
		rd_chk(INTR_STAT_ADDR, 32'h0000_0f00, "gc frame");
		rd_chk(CLR_GEN_CALL_ADDR, 32'h0, "gc clear");
		rd_chk(INTR_STAT_ADDR, 32'h0000_0700, "gc cleared");
		rd_chk(CLR_INTR_ADDR, 32'h0, "all clear");
		rd_chk(INTR_STAT_ADDR, 32'h0, "all cleared");
	endtask

	task automatic t_other_addr();
		logic ack;
		master_u.start_cond();
		master_u.send_byte(8'ha0, ack);
		`CHK(ack, 1'b0, "no ack")
		rd_chk(CLR_INTR_ADDR, 32'h0, "all clear");
		master_u.start_cond();
		rd_chk(INTR_STAT_ADDR, 32'h0000_0500, "restart");
		master_u.send_byte(8'h11, ack);
		master_u.stop_cond();
		rd_chk(INTR_STAT_ADDR, 32'h0000_0700, "other frame");
		`CHK(rx_count, 1, "no delivery")
		wr(ENABLE_ADDR, 32'h0);
		rd_chk(INTR_STAT_ADDR, 32'h0, "disabled");
	endtask

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#300000;
		miscompares++;
		$display("MISMATCH %0t watchdog expired", $time);
		end_of_test();
	end

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		core_active = 1'b0;
		special_send = 1'b0;
		std_low_count = 16'h00aa;
		rx_last = 8'h00;
		rx_count = 0;
		miscompares = 0;
		n_compared = 0;
		// Reset must also cover four edges of the slower link clock
		repeat (4) @(posedge link_clk);
		@(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_count();
		t_status();
		t_activity();
		t_gen_call();
		wr(ENABLE_ADDR, 32'h0000_0001);
		t_other_addr();
		end_of_test();
	end
endmodule

//--- test/i2c_master_model.sv
// Behavioural I2C bus master driving SCL and its side of open-drain SDA
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic link_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wait_lc(input int n);
		repeat (n) @(posedge link_clk);
	endtask

	// Works from idle and as a repeated START with SCL low
	task automatic start_cond();
		wait_lc(1);
		sda_drv <= 1'b1;
		wait_lc(2);
		scl <= 1'b1;
		wait_lc(2);
		sda_drv <= 1'b0;
		wait_lc(4);
		scl <= 1'b0;
		wait_lc(2);
	endtask

	// Eight bits MSB first, then a ninth clock with SDA released
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_drv <= b[i];
			wait_lc(2);
			scl <= 1'b1;
			wait_lc(4);
			scl <= 1'b0;
			wait_lc(2);
		end
		sda_drv <= 1'b1;
		wait_lc(3);
		scl <= 1'b1;
		wait_lc(2);
		ack = ~sda_line;
		wait_lc(2);
		scl <= 1'b0;
		wait_lc(2);
	endtask

	task automatic stop_cond();
		sda_drv <= 1'b0;
		wait_lc(2);
		scl <= 1'b1;
		wait_lc(4);
		sda_drv <= 1'b1;
		wait_lc(8);
	endtask
endmodule
